// >>> bench/osc_model.sv
// Behavioural resonators for the raw oscillator inputs
`timescale 1ns/10ps
`default_nettype none
module osc_model (
    // Enables in main, sub, slow, fast order
    input wire logic [3:0] enable_i,
    // Raw oscillator waveforms
    output var logic [3:0] osc_o
);
    // Half periods avoid multiples of 40 ns so phases drift against clk_i
    localparam int HALF_NS [4] = '{130, 230, 170, 150};
    for (genvar g = 0; g < 4; g++) begin : g_osc
        // clean swing once enabled
        // Rest low when stopped, never hold a stale high
        initial begin
            osc_o[g] = 1'b0;
            forever begin
                #(HALF_NS[g]);
                osc_o[g] = (enable_i[g] === 1'b1) ? ~osc_o[g] : 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/system_clock_generator_props.sv
// Port-level assertions for the system clock generator
`timescale 1ns/10ps
`default_nettype none
module system_clock_generator_props (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    // Power requests
    input wire logic wait_request_i,
    input wire logic stop_request_i,
    input wire logic wake_i,
    // Oscillators and clocks
    input wire logic main_osc_enable_o,
    input wire logic sub_osc_enable_o,
    input wire logic hs_osc_enable_o,
    input wire logic sub_feedback_connect_o,
    input wire logic fast_timer_clock_o,
    input wire logic converter_clock_o,
    input wire logic cpu_clock_o,
    input var clock_gen_pkg::power_state_t power_state_o
);
    // One domain, so checks sleep while reset is high
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Power state decodes and main, sub or fast oscillator enabled
    wire logic run = power_state_o == clock_gen_pkg::PWR_RUN;
    wire logic stop = power_state_o == clock_gen_pkg::PWR_STOP;
    wire logic osc_on = main_osc_enable_o || sub_osc_enable_o || hs_osc_enable_o;

    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_prompt: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered");
    a_reset_osc_off: assert property ($fell(rst_i) |-> !osc_on)
        else $error("oscillator running out of reset");
    a_stop_halts: assert property (stop |-> !osc_on)
        else $error("oscillator enabled in stop");
    a_stop_feedback: assert property (stop |-> !sub_feedback_connect_o)
        else $error("feedback resistor connected in stop");
    a_stop_entry: assert property (stop_request_i && run |-> ##2 stop)
        else $error("stop not entered");
    a_wait_entry:
        assert property (wait_request_i && !stop_request_i && run
            |-> ##2 power_state_o == clock_gen_pkg::PWR_WAIT)
        else $error("wait not entered");
    a_wake_exit: assert property (wake_i && !run |-> ##2 run)
        else $error("wake did not return to run");
    a_cpu_no_runt: assert property ($changed(cpu_clock_o) |=> $stable(cpu_clock_o))
        else $error("runt pulse on cpu clock");
    a_fast_gated:
        assert property (!hs_osc_enable_o [*8] |-> !(fast_timer_clock_o || converter_clock_o))
        else $error("fast clocks run with oscillator off");
endmodule

bind system_clock_generator system_clock_generator_props i_props (
    .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .wait_request_i, .stop_request_i, .wake_i,
    .main_osc_enable_o, .sub_osc_enable_o, .hs_osc_enable_o, .sub_feedback_connect_o,
    .fast_timer_clock_o, .converter_clock_o, .cpu_clock_o, .power_state_o
);
`default_nettype wire

// >>> bench/system_clock_generator_tb.sv
// Self-checking bench for the system clock generator
`timescale 1ns/10ps
`default_nettype none
module system_clock_generator_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [2:0] req = 3'h0;
    logic csp = 1'b0;
    wire logic fb;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic ack_o;
    wire logic [3:0] en;
    wire logic [7:0] trim;
    wire logic [15:0] mon;
    clock_gen_pkg::clock_mode_t mode;
    clock_gen_pkg::power_state_t pwr;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;

    // Design and resonators; mon gathers every clock for edge counting
    system_clock_generator i_dut (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hF), .dat_i, .dat_o, .ack_o,
        .main_oscillator_clock_i(mon[12]), .sub_oscillator_clock_i(mon[13]),
        .ls_osc_clock_i(mon[14]), .hs_osc_clock_i(mon[15]), .count_source_protect_i(csp),
        .stop_request_i(req[2]), .wait_request_i(req[1]), .wake_i(req[0]),
        .main_osc_enable_o(en[0]), .sub_osc_enable_o(en[1]), .ls_osc_enable_o(en[2]),
        .hs_osc_enable_o(en[3]), .sub_feedback_connect_o(fb), .hs_osc_trim_o(trim),
        .cpu_clock_o(mon[0]), .prescaled_periph_clocks_o(mon[5:1]),
        .int_osc_periph_clock_o(mon[6]), .fast_timer_clock_o(mon[7]),
        .converter_clock_o(mon[8]), .watchdog_detector_clock_o(mon[9]),
        .calendar_timer_clock_o(mon[10]), .general_timer_sub_clock_o(mon[11]),
        .clock_mode_o(mode), .power_state_o(pwr)
    );
    osc_model i_osc (.enable_i(en), .osc_o(mon[15:12]));

    // 25 MHz system clock
    always #20 clk_i = ~clk_i;

    // Hang guard, about twice the planned run
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // One-cycle power request {stop, wait, wake}, then let the state land
    task automatic power(input logic [2:0] p);
        req <= p;
        @(posedge clk_i);
        req <= 3'h0;
        repeat (3) @(posedge clk_i);
    endtask

    // Clock a must show one rise per r rises of clock b; r of 0 means stopped
    task automatic ratio(input int a, input int b, input int r);
        int ca = 0;
        int cb = 0;
        logic [15:0] prev;
        repeat (40) @(posedge clk_i);
        prev = mon;
        repeat (1600) begin
            @(posedge clk_i);
            ca += int'(mon[a] & ~prev[a]);
            cb += int'(mon[b] & ~prev[b]);
            prev = mon;
        end
        n_compared++;
        if (cb < 8 || (r == 0 ? ca != 0 : (ca * r - cb > r + 1 || cb - ca * r > r + 1))) begin
            errors++;
            $display("BAD %0t clock %0d rose %0d times against %0d", $time, a, ca, cb);
        end
    endtask

    task automatic t_regs;
        logic [7:0] ad[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'hFC};
        logic [11:0] ex[6] = '{12'h010, 12'h020, 12'h080, 12'h080, 12'h060, 12'h000};
        chk(en, 32'h4, "reset enables");
        chk(mode, 32'h10, "reset mode");
        ratio(0, 14, 8);
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, ad[i], 32'h0);
            chk(rd, 32'(ex[i]), "reset read");
        end
        wb(1'b1, 8'h00, 32'h012);
        wb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h010, "locked write");
        wb(1'b1, 8'h14, 32'h1);
        wb(1'b1, 8'h0C, 32'h055);
        wb(1'b1, 8'h08, 32'h000);
        wb(1'b1, 8'h08, 32'h020);
        wb(1'b1, 8'h08, 32'h060);
        wb(1'b0, 8'h0C, 32'h0);
        chk({rd[7:0], trim}, 32'h8060, "trim copy");
    endtask

    // Every divide code against the slow internal oscillator
    task automatic t_divide;
        int r[5] = '{1, 2, 4, 16, 8};
        int p[5] = '{1, 2, 4, 8, 32};
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, 8'h00, (i == 4) ? 32'h010 : 32'(i) << 8);
            ratio(0, 14, r[i]);
            ratio(i + 1, 14, p[i]);
        end
        ratio(6, 14, 1);
    endtask

    // Each external source is started before it is selected; the fast internal one is started by the write that selects it
    task automatic t_sources;
        wb(1'b1, 8'h00, 32'h000);
        wb(1'b1, 8'h04, 32'h02B);
        ratio(0, 15, 4);
        ratio(7, 15, 1);
        ratio(8, 15, 1);
        chk(mode, 32'h08, "fast internal");
        wb(1'b1, 8'h00, 32'h005);
        wb(1'b1, 8'h04, 32'h003);
        ratio(0, 13, 1);
        ratio(10, 13, 4);
        ratio(11, 13, 32);
        chk({mode, en[1]}, 32'h09, "slow external");
        csp <= 1'b1;
        wb(1'b1, 8'h00, 32'h085);
        ratio(9, 14, 1);
        csp <= 1'b0;
        ratio(9, 13, 0);
        wb(1'b1, 8'h04, 32'h023);
        // Let the swap to the fast oscillator land before the sub source stops
        repeat (40) @(posedge clk_i);
        wb(1'b1, 8'h00, 32'h060);
        wb(1'b1, 8'h04, 32'h003);
        ratio(0, 12, 1);
        chk(mode, 32'h02, "fast external");
    endtask

    task automatic t_power;
        power(3'h4);
        chk({pwr, en, fb}, 32'h80, "stop");
        wb(1'b0, 8'h00, 32'h0);
        chk(rd[4], 32'h1, "divide by eight");
        power(3'h1);
        chk({pwr, fb}, 32'h3, "run");
        wb(1'b1, 8'h04, 32'h0C0);
        wb(1'b1, 8'h00, 32'h048);
        repeat (300) @(posedge clk_i);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd[5], 32'h1, "forced internal");
        wb(1'b1, 8'h00, 32'h012);
        power(3'h2);
        chk(pwr, 32'h2, "wait");
        ratio(1, 14, 0);
        ratio(6, 14, 1);
        ratio(9, 14, 1);
        power(3'h1);
    endtask

    task automatic final_report;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Reset, then the scenarios in order
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        t_regs();
        t_divide();
        t_sources();
        t_power();
        final_report();
    end
endmodule
`default_nettype wire

// >>> shared/clock_gen_pkg.sv
// Shared constants and types for the system clock generator
package clock_gen_pkg;

    // ********************************************
    // Register map
    // ********************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_OSC = 8'h04;
    localparam logic [7:0] REG_TRIM = 8'h08;
    localparam logic [7:0] REG_TRIM_MID = 8'h0C;
    localparam logic [7:0] REG_TRIM_LOW = 8'h10;
    localparam logic [7:0] REG_PROTECT = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;

    // Reset values and the full stop detect setting
    localparam logic [9:0] CTRL_RESET = 10'h010;
    localparam logic [7:0] OSC_RESET = 8'h20;
    localparam logic [1:0] DETECT_FULL = 2'h3;

    // Main clock loss timeout
    localparam int STOP_DETECT_NS = 10000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int STOP_DETECT_CYCLES = STOP_DETECT_NS / CLK_PERIOD_NS;

    // Source index in the oscillator arrays
    localparam int SRC_MAIN = 0;
    localparam int SRC_SUB = 1;
    localparam int SRC_LOW = 2;
    localparam int SRC_HIGH = 3;

    // ********************************************
    // Types
    // ********************************************
    typedef struct packed {
        logic cpu_divide_field_high;
        logic cpu_divide_field_low;
        logic low_speed_osc_off;
        logic main_pin_function;
        logic sub_feedback_resistor_ctrl;
        logic cpu_divide_by_eight;
        logic main_osc_stop;
        logic sub_pin_function;
        logic periph_clock_stop_in_wait;
        logic external_source_sub;
    } ctrl_t;

    typedef struct packed {
        logic stop_detect_interrupt_enable;
        logic stop_detect_enable;
        logic system_source_select;
        logic [2:0] hs_osc_divide_field;
        logic int_osc_select_fast;
        logic hs_osc_on;
    } osc_t;

    typedef struct packed {
        logic div32;
        logic div8;
        logic div4;
        logic div2;
        logic div1;
    } prescale_t;

    typedef enum logic [4:0] {
        MODE_NONE = 5'h01,
        MODE_HS_EXT = 5'h02,
        MODE_LS_EXT = 5'h04,
        MODE_HS_INT = 5'h08,
        MODE_LS_INT = 5'h10
    } clock_mode_t;

    typedef enum logic [2:0] {
        PWR_RUN = 3'h1,
        PWR_WAIT = 3'h2,
        PWR_STOP = 3'h4
    } power_state_t;

endpackage

// >>> src/system_clock_generator.sv
// System clock generator: oscillator gating, source select, dividers, power modes
//
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module system_clock_generator #(
    parameter logic [7:0] TRIM_MID_VALUE = 8'h80,
    parameter logic [7:0] TRIM_LOW_VALUE = 8'h60
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Raw oscillator outputs, asynchronous
    input wire logic main_oscillator_clock_i,
    input wire logic sub_oscillator_clock_i,
    input wire logic ls_osc_clock_i,
    input wire logic hs_osc_clock_i,
    // Power requests and count source protect from the core, on clk_i
    input wire logic wait_request_i,
    input wire logic stop_request_i,
    input wire logic wake_i,
    input wire logic count_source_protect_i,
    // Oscillator controls
    output logic main_osc_enable_o,
    output logic sub_osc_enable_o,
    output logic ls_osc_enable_o,
    output logic hs_osc_enable_o,
    output logic sub_feedback_connect_o,
    output logic [7:0] hs_osc_trim_o,
    // Generated clocks
    output logic cpu_clock_o,
    output var clock_gen_pkg::prescale_t prescaled_periph_clocks_o,
    output logic int_osc_periph_clock_o,
    output logic fast_timer_clock_o,
    output logic converter_clock_o,
    output logic watchdog_detector_clock_o,
    output logic calendar_timer_clock_o,
    output logic general_timer_sub_clock_o,
    // Mode report
    output var clock_gen_pkg::clock_mode_t clock_mode_o,
    output var clock_gen_pkg::power_state_t power_state_o
);

    // ********************************************
    // Declarations
    // ********************************************
    clock_gen_pkg::ctrl_t ctrl;
    clock_gen_pkg::osc_t osc;
    clock_gen_pkg::power_state_t pwr;
    clock_gen_pkg::clock_mode_t next_mode;
    logic [7:0] trim;
    logic protect;
    logic [3:0] src_raw;
    logic [3:0] src_run;
    logic [3:0] src_lvl;
    logic [3:0] src_rise;
    logic src_meta [4];
    logic src_sync [4];
    logic src_prev [4];
    logic [7:0] src_cnt [4];
    logic hs_div_lvl;
    logic int_lvl;
    logic [1:0] sys_sel;
    logic [1:0] sys_want;
    logic sys_lvl;
    logic sys_prev;
    logic [4:0] sys_cnt;
    logic [2:0] cpu_code;
    logic [2:0] cpu_want;
    logic cpu_lvl;
    logic cpu_fresh;
    logic stopped;
    logic main_lost;
    logic [15:0] miss_cnt;
    logic acc;
    logic wr;
    logic [15:0] wmask;
    logic [31:0] next_dat;

    // Tap of a ripple counter: code 0 is the source itself
    function automatic logic tap(input logic [7:0] c, input logic s, input logic [2:0] k);
        tap = (k == 3'h0) ? s : c[k - 3'h1];
    endfunction

    // Level of a system source by its select code
    function automatic logic pick(input logic [1:0] sel, input logic [3:0] lvl,
                                  input logic il);
        case (sel)
            2'h0: pick = lvl[clock_gen_pkg::SRC_MAIN];
            2'h1: pick = lvl[clock_gen_pkg::SRC_SUB];
            2'h2: pick = lvl[clock_gen_pkg::SRC_LOW];
            default: pick = il;
        endcase
    endfunction

    // ********************************************
    // Oscillator gating and synchronisers
    // ********************************************
    assign stopped = (pwr == clock_gen_pkg::PWR_STOP);
    assign src_raw = {hs_osc_clock_i, ls_osc_clock_i, sub_oscillator_clock_i,
                      main_oscillator_clock_i};

    // Which oscillators may run
    always_comb begin
        src_run[clock_gen_pkg::SRC_HIGH] = osc.hs_osc_on & ~stopped;
        src_run[clock_gen_pkg::SRC_LOW] = (~ctrl.low_speed_osc_off | count_source_protect_i)
                                          & ~stopped;
        src_run[clock_gen_pkg::SRC_SUB] = ctrl.external_source_sub & ctrl.sub_pin_function
                                          & ~stopped;
        src_run[clock_gen_pkg::SRC_MAIN] = ctrl.main_pin_function & ~ctrl.main_osc_stop
                                           & ~stopped;
    end

    // Two flops per oscillator, then a counter of its rising edges
    generate
        for (genvar i = 0; i < 4; i++) begin : g_src
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    src_meta[i] <= 1'b0;
                    src_sync[i] <= 1'b0;
                    src_prev[i] <= 1'b0;
                    src_cnt[i] <= 8'h00;
                end else begin
                    src_meta[i] <= src_raw[i];
                    src_sync[i] <= src_meta[i];
                    src_prev[i] <= src_sync[i];
                    if (!src_run[i]) begin
                        src_cnt[i] <= 8'h00;
                    end else if (src_rise[i]) begin
                        src_cnt[i] <= src_cnt[i] + 8'h01;
                    end
                end
            end
            assign src_lvl[i] = src_sync[i] & src_run[i];
            assign src_rise[i] = src_sync[i] & ~src_prev[i];
        end
    endgenerate

    assign hs_div_lvl = tap(src_cnt[clock_gen_pkg::SRC_HIGH], src_lvl[clock_gen_pkg::SRC_HIGH],
                            osc.hs_osc_divide_field);
    assign int_lvl = osc.int_osc_select_fast ? hs_div_lvl : src_lvl[clock_gen_pkg::SRC_LOW];

    // ********************************************
    // System clock and CPU divider
    // ********************************************
    // source select
    // The fast/slow internal choice is a select code too, so it swaps glitch-free
    assign sys_want = osc.system_source_select ? {1'b1, osc.int_osc_select_fast}
                                               : {1'b0, ctrl.external_source_sub};
    assign sys_lvl = pick(sys_sel, src_lvl, hs_div_lvl);

    always_comb begin
        if (ctrl.cpu_divide_by_eight) begin
            cpu_want = 3'h3;
        end else begin
            case ({ctrl.cpu_divide_field_high, ctrl.cpu_divide_field_low})
                2'h0: cpu_want = 3'h0;
                2'h1: cpu_want = 3'h1;
                2'h2: cpu_want = 3'h2;
                default: cpu_want = 3'h4;
            endcase
        end
    end
    assign cpu_lvl = (cpu_code == 3'h0) ? sys_lvl : sys_cnt[cpu_code - 3'h1];

    // switch only while low
    // A source that has died high never lets this pass; loss detection overrides it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_sel <= 2'h2;
        end else if (sys_want != sys_sel) begin
            if ((!sys_lvl || main_lost) && !pick(sys_want, src_lvl, hs_div_lvl)) begin
                sys_sel <= sys_want;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_code <= 3'h3;
        end else if (cpu_want != cpu_code && !cpu_lvl) begin
            if (cpu_want == 3'h0 ? !sys_lvl : !sys_cnt[cpu_want - 3'h1]) begin
                cpu_code <= cpu_want;
            end
        end
    end

    // System edge counter feeding CPU and peripheral taps
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_prev <= 1'b0;
            sys_cnt <= 5'h00;
        end else begin
            sys_prev <= sys_lvl;
            if (sys_lvl && !sys_prev) begin
                sys_cnt <= sys_cnt + 5'h01;
            end
        end
    end

    // ********************************************
    // Power state and main clock loss
    // ********************************************
    // run, wait, stop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr <= clock_gen_pkg::PWR_RUN;
        end else begin
            case (pwr)
                clock_gen_pkg::PWR_RUN: begin
                    if (stop_request_i) begin
                        pwr <= clock_gen_pkg::PWR_STOP;
                    end else if (wait_request_i) begin
                        pwr <= clock_gen_pkg::PWR_WAIT;
                    end
                end
                clock_gen_pkg::PWR_WAIT,
                clock_gen_pkg::PWR_STOP: begin
                    if (wake_i) begin
                        pwr <= clock_gen_pkg::PWR_RUN;
                    end
                end
                default: pwr <= clock_gen_pkg::PWR_RUN;
            endcase
        end
    end

    // Main clock counted as lost after a timeout with no edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            miss_cnt <= 16'h0000;
            main_lost <= 1'b0;
        end else if (!osc.stop_detect_enable || src_rise[clock_gen_pkg::SRC_MAIN]) begin
            miss_cnt <= 16'h0000;
            main_lost <= 1'b0;
        end else if (miss_cnt == 16'(clock_gen_pkg::STOP_DETECT_CYCLES)) begin
            main_lost <= 1'b1;
        end else begin
            miss_cnt <= miss_cnt + 16'h0001;
        end
    end

    always_comb begin
        next_mode = clock_gen_pkg::MODE_NONE;
        if (!osc.system_source_select) begin
            if (!ctrl.external_source_sub && ctrl.main_pin_function && !ctrl.main_osc_stop) begin
                next_mode = clock_gen_pkg::MODE_HS_EXT;
            end else if (ctrl.external_source_sub && ctrl.sub_pin_function) begin
                next_mode = clock_gen_pkg::MODE_LS_EXT;
            end
        end else if (osc.int_osc_select_fast && osc.hs_osc_on) begin
            next_mode = clock_gen_pkg::MODE_HS_INT;
        end else if (!osc.int_osc_select_fast && !ctrl.low_speed_osc_off) begin
            next_mode = clock_gen_pkg::MODE_LS_INT;
        end
    end

    // ********************************************
    // Wishbone register access
    // ********************************************
    assign acc = cyc_i & stb_i & ~ack_o;
    // Write lands on the edge at which the master sees ack
    assign wr = cyc_i & stb_i & we_i & ack_o;
    assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= acc;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        next_dat = 32'h0000_0000;
        case (adr_i)
            clock_gen_pkg::REG_CTRL: next_dat[9:0] = ctrl;
            clock_gen_pkg::REG_OSC: next_dat[7:0] = osc;
            clock_gen_pkg::REG_TRIM: next_dat[7:0] = trim;
            clock_gen_pkg::REG_TRIM_MID: next_dat[7:0] = TRIM_MID_VALUE;
            clock_gen_pkg::REG_TRIM_LOW: next_dat[7:0] = TRIM_LOW_VALUE;
            clock_gen_pkg::REG_PROTECT: next_dat[0] = protect;
            clock_gen_pkg::REG_STATUS: next_dat[8:0] = {main_lost, pwr, next_mode};
            default: next_dat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (acc) begin
            dat_o <= next_dat;
        end
    end

    // Protect bit itself is always writable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            protect <= 1'b0;
        end else if (wr && sel_i[0] && adr_i == clock_gen_pkg::REG_PROTECT) begin
            protect <= dat_i[0];
        end
    end

    // Control registers; hardware sets land after software writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= clock_gen_pkg::CTRL_RESET;
            osc <= clock_gen_pkg::OSC_RESET;
            trim <= TRIM_MID_VALUE;
        end else begin
            if (wr && protect) begin
                if (adr_i == clock_gen_pkg::REG_CTRL) begin
                    ctrl <= (ctrl & ~wmask[9:0]) | (dat_i[9:0] & wmask[9:0]);
                end
                if (adr_i == clock_gen_pkg::REG_OSC && sel_i[0]) begin
                    osc <= dat_i[7:0];
                end
                if (adr_i == clock_gen_pkg::REG_TRIM && sel_i[0]) begin
                    trim <= dat_i[7:0];
                end
            end
            if (pwr == clock_gen_pkg::PWR_RUN && stop_request_i
                && next_mode == clock_gen_pkg::MODE_HS_EXT) begin
                ctrl.cpu_divide_by_eight <= 1'b1;
            end
            if (main_lost && {osc.stop_detect_interrupt_enable, osc.stop_detect_enable}
                == clock_gen_pkg::DETECT_FULL) begin
                osc.system_source_select <= 1'b1;
            end
        end
    end

    // ********************************************
    // Registered outputs
    // ********************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            main_osc_enable_o <= 1'b0;
            sub_osc_enable_o <= 1'b0;
            ls_osc_enable_o <= 1'b0;
            hs_osc_enable_o <= 1'b0;
            sub_feedback_connect_o <= 1'b0;
            hs_osc_trim_o <= 8'h00;
            clock_mode_o <= clock_gen_pkg::MODE_NONE;
            power_state_o <= clock_gen_pkg::PWR_RUN;
        end else begin
            main_osc_enable_o <= src_run[clock_gen_pkg::SRC_MAIN];
            sub_osc_enable_o <= src_run[clock_gen_pkg::SRC_SUB];
            ls_osc_enable_o <= src_run[clock_gen_pkg::SRC_LOW];
            hs_osc_enable_o <= src_run[clock_gen_pkg::SRC_HIGH];
            sub_feedback_connect_o <= ctrl.sub_feedback_resistor_ctrl & ~stopped;
            hs_osc_trim_o <= trim;
            clock_mode_o <= next_mode;
            power_state_o <= pwr;
        end
    end

    // Clock outputs; all low in reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_clock_o <= 1'b0;
            cpu_fresh <= 1'b0;
            prescaled_periph_clocks_o <= 5'h00;
            int_osc_periph_clock_o <= 1'b0;
            fast_timer_clock_o <= 1'b0;
            converter_clock_o <= 1'b0;
            watchdog_detector_clock_o <= 1'b0;
            calendar_timer_clock_o <= 1'b0;
            general_timer_sub_clock_o <= 1'b0;
        end else begin
            // CPU clock halts in wait and stop
            // every level stands at least two cycles
            if (!cpu_fresh) begin
                cpu_clock_o <= cpu_lvl & (pwr == clock_gen_pkg::PWR_RUN);
            end
            // Gating or a killed source could otherwise cut a one-cycle runt
            cpu_fresh <= !cpu_fresh
                         && ((cpu_lvl & (pwr == clock_gen_pkg::PWR_RUN)) != cpu_clock_o);
            if (pwr == clock_gen_pkg::PWR_WAIT && ctrl.periph_clock_stop_in_wait) begin
                prescaled_periph_clocks_o <= 5'h00;
            end else begin
                prescaled_periph_clocks_o <= {sys_cnt[4], sys_cnt[2], sys_cnt[1],
                                              sys_cnt[0], sys_lvl};
            end
            int_osc_periph_clock_o <= int_lvl;
            fast_timer_clock_o <= src_lvl[clock_gen_pkg::SRC_HIGH];
            converter_clock_o <= src_lvl[clock_gen_pkg::SRC_HIGH];
            watchdog_detector_clock_o <= src_lvl[clock_gen_pkg::SRC_LOW];
            calendar_timer_clock_o <= src_cnt[clock_gen_pkg::SRC_SUB][1];
            general_timer_sub_clock_o <= src_cnt[clock_gen_pkg::SRC_SUB][4];
        end
    end

endmodule
`default_nettype wire
